// [hw/rca_calendar.sv]
// calendar count and first alarm set point registers of the real-time clock
`timescale 1ns/1ps
`default_nettype none
`include "rca_defines.svh"
module rca_calendar
	import rca_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// one-second tick from the clock divider, same clock domain
	input wire logic tick_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// alarm condition level
	output logic alarm_o
);
	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	rca_reg_if reg_if ();

	rca_wb_slave u_slave (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.we_i (we_i),
		.adr_i (adr_i),
		.sel_i (sel_i),
		.dat_i (dat_i),
		.dat_o (dat_o),
		.ack_o (ack_o),
		.reg_if (reg_if.slave)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rca_byte_t sec_ff;
	rca_byte_t min_ff;
	rca_byte_t hrs_ff;
	logic [3:0] weekday_value_ff;
	rca_byte_t month_day_count_ff;
	rca_byte_t month_count_reg_ff;
	rca_byte_t year_count_reg_ff;
	rca_byte_t hundred_year_reg_ff;
	rca_byte_t alarm_second_point_ff;
	rca_byte_t alarm_minute_point_ff;
	logic unlock_ff;
	logic bcd_en_ff;
	logic alarm_second_ones_en_ff;
	logic alarm_minute_ones_en_ff;
	logic alarm_ff;
	logic cmp_req_ff;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic hit_sec;
	wire logic hit_min;
	wire logic hit_hrs;
	wire logic hit_wday;
	wire logic hit_mday;
	wire logic hit_mon;
	wire logic hit_yr;
	wire logic hit_cen;
	wire logic hit_alarm_second_ones;
	wire logic hit_alarm_minute_ones;
	wire logic hit_ctrl;
	wire logic cnt_wr;

	assign hit_sec = (reg_if.idx == `RCA_IDX_SEC);
	assign hit_min = (reg_if.idx == `RCA_IDX_MIN);
	assign hit_hrs = (reg_if.idx == `RCA_IDX_HRS);
	assign hit_wday = (reg_if.idx == `RCA_IDX_WDAY);
	assign hit_mday = (reg_if.idx == `RCA_IDX_MDAY);
	assign hit_mon = (reg_if.idx == `RCA_IDX_MON);
	assign hit_yr = (reg_if.idx == `RCA_IDX_YR);
	assign hit_cen = (reg_if.idx == `RCA_IDX_CEN);
	assign hit_alarm_second_ones = (reg_if.idx == `RCA_IDX_ALARM_SECOND_ONES);
	assign hit_alarm_minute_ones = (reg_if.idx == `RCA_IDX_ALARM_MINUTE_ONES);
	assign hit_ctrl = (reg_if.idx == `RCA_IDX_CTRL);

	// count writes pass only while unlocked; locked writes are dropped
	assign cnt_wr = reg_if.wr_stb & unlock_ff;

	// ----------------------------------------------------------------
	// write enables
	// ----------------------------------------------------------------
	wire logic wr_sec;
	wire logic wr_min;
	wire logic wr_hrs;
	wire logic wr_wday;
	wire logic wr_mday;
	wire logic wr_mon;
	wire logic wr_yr;
	wire logic wr_cen;
	wire logic wr_alarm_second_ones;
	wire logic wr_alarm_minute_ones;

	// count fields need the unlock; set points take a write at any time
	assign wr_sec = cnt_wr & hit_sec;
	assign wr_min = cnt_wr & hit_min;
	assign wr_hrs = cnt_wr & hit_hrs;
	assign wr_wday = cnt_wr & hit_wday;
	assign wr_mday = cnt_wr & hit_mday;
	assign wr_mon = cnt_wr & hit_mon;
	assign wr_yr = cnt_wr & hit_yr;
	assign wr_cen = cnt_wr & hit_cen;
	assign wr_alarm_second_ones = reg_if.wr_stb & hit_alarm_second_ones;
	assign wr_alarm_minute_ones = reg_if.wr_stb & hit_alarm_minute_ones;

	// ----------------------------------------------------------------
	// count chain
	// ----------------------------------------------------------------
	wire logic advance;
	wire logic c_sec;
	wire logic c_min;
	wire logic c_hrs;
	wire logic c_mday;
	wire logic c_mon;
	wire logic c_yr;
	wire logic [7:0] wday_cur;
	wire logic [7:0] nxt_sec;
	wire logic [7:0] nxt_min;
	wire logic [7:0] nxt_hrs;
	wire logic [7:0] nxt_wday;
	wire logic [7:0] nxt_mday;
	wire logic [7:0] nxt_mon;
	wire logic [7:0] nxt_yr;
	wire logic [7:0] nxt_cen;

	// counting halts while unlocked so software can set the time
	assign advance = tick_i & !unlock_ff;
	assign wday_cur = {4'h0, weekday_value_ff};

	// seconds and minutes share limits; the carry walks the chain
	rca_step u_sec (
		.cur_i (sec_ff), .bcd_i (bcd_en_ff), .inc_i (advance),
		.min_i (`RCA_MIN_ZERO), .max_bin_i (`RCA_SEC_MAX_BIN),
		.max_bcd_i (`RCA_SEC_MAX_BCD), .nxt_o (nxt_sec), .carry_o (c_sec)
	);
	rca_step u_min (
		.cur_i (min_ff), .bcd_i (bcd_en_ff), .inc_i (c_sec),
		.min_i (`RCA_MIN_ZERO), .max_bin_i (`RCA_SEC_MAX_BIN),
		.max_bcd_i (`RCA_SEC_MAX_BCD), .nxt_o (nxt_min), .carry_o (c_min)
	);
	rca_step u_hrs (
		.cur_i (hrs_ff), .bcd_i (bcd_en_ff), .inc_i (c_min),
		.min_i (`RCA_MIN_ZERO), .max_bin_i (`RCA_HRS_MAX_BIN),
		.max_bcd_i (`RCA_HRS_MAX_BCD), .nxt_o (nxt_hrs), .carry_o (c_hrs)
	);
	// weekday: 1 to 7 in both formats
	rca_step u_wday (
		.cur_i (wday_cur), .bcd_i (bcd_en_ff), .inc_i (c_hrs),
		.min_i (`RCA_MIN_ONE), .max_bin_i (`RCA_WDAY_MAX),
		.max_bcd_i (`RCA_WDAY_MAX), .nxt_o (nxt_wday), .carry_o ()
	);
	// day of month starts at one and wraps to one
	rca_step u_mday (
		.cur_i (month_day_count_ff), .bcd_i (bcd_en_ff),
		.inc_i (c_hrs), .min_i (`RCA_MIN_ONE),
		.max_bin_i (`RCA_MDAY_MAX_BIN), .max_bcd_i (`RCA_MDAY_MAX_BCD),
		.nxt_o (nxt_mday), .carry_o (c_mday)
	);
	rca_step u_mon (
		.cur_i (month_count_reg_ff), .bcd_i (bcd_en_ff),
		.inc_i (c_mday), .min_i (`RCA_MIN_ONE),
		.max_bin_i (`RCA_MON_MAX_BIN), .max_bcd_i (`RCA_MON_MAX_BCD),
		.nxt_o (nxt_mon), .carry_o (c_mon)
	);
	rca_step u_yr (
		.cur_i (year_count_reg_ff), .bcd_i (bcd_en_ff),
		.inc_i (c_mon), .min_i (`RCA_MIN_ZERO),
		.max_bin_i (`RCA_YR_MAX_BIN), .max_bcd_i (`RCA_YR_MAX_BCD),
		.nxt_o (nxt_yr), .carry_o (c_yr)
	);
	rca_step u_cen (
		.cur_i (hundred_year_reg_ff), .bcd_i (bcd_en_ff),
		.inc_i (c_yr), .min_i (`RCA_MIN_ZERO),
		.max_bin_i (`RCA_YR_MAX_BIN), .max_bcd_i (`RCA_YR_MAX_BCD),
		.nxt_o (nxt_cen), .carry_o ()
	);

	// ----------------------------------------------------------------
	// count registers: no reset, so time survives a system reset
	// ----------------------------------------------------------------
	// writes and advance never meet: writes need unlock, advance needs lock
	always_ff @(posedge clk_i) begin
		sec_ff <= wr_sec ? reg_if.wdata : nxt_sec;
		min_ff <= wr_min ? reg_if.wdata : nxt_min;
		hrs_ff <= wr_hrs ? reg_if.wdata : nxt_hrs;
	end

	// only the low nibble of weekday is stored
	always_ff @(posedge clk_i) begin
		if (wr_wday) weekday_value_ff <= reg_if.wdata[3:0];
		else weekday_value_ff <= nxt_wday[3:0];
	end

	// day of month: a written value is kept as is, never corrected
	always_ff @(posedge clk_i) begin
		if (wr_mday) month_day_count_ff <= reg_if.wdata;
		else month_day_count_ff <= nxt_mday;
	end

	// month
	always_ff @(posedge clk_i) begin
		if (wr_mon) month_count_reg_ff <= reg_if.wdata;
		else month_count_reg_ff <= nxt_mon;
	end

	// year
	always_ff @(posedge clk_i) begin
		if (wr_yr) year_count_reg_ff <= reg_if.wdata;
		else year_count_reg_ff <= nxt_yr;
	end

	// century: steps only on the year carry
	always_ff @(posedge clk_i) begin
		if (wr_cen) hundred_year_reg_ff <= reg_if.wdata;
		else hundred_year_reg_ff <= nxt_cen;
	end

	// ----------------------------------------------------------------
	// alarm set points: writable at any time, kept through reset
	// ----------------------------------------------------------------
	// the value is stored as written; the format bit decides its meaning
	always_ff @(posedge clk_i) begin
		if (wr_alarm_second_ones)
			alarm_second_point_ff <= reg_if.wdata;
	end

	// alarm minutes set point
	always_ff @(posedge clk_i) begin
		if (wr_alarm_minute_ones)
			alarm_minute_point_ff <= reg_if.wdata;
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	wire logic ctrl_wr;
	wire logic lock_cmp;

	assign ctrl_wr = reg_if.wr_stb & hit_ctrl;
	// writing zero to unlock forces a compare, whatever its old value
	assign lock_cmp = ctrl_wr & !reg_if.wdata[`RCA_CTRL_UNLOCK];

	// reset leaves the counts locked and alarms disabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unlock_ff <= 1'b0;
			bcd_en_ff <= 1'b0;
			alarm_second_ones_en_ff <= 1'b0;
			alarm_minute_ones_en_ff <= 1'b0;
		end else if (ctrl_wr) begin
			unlock_ff <= reg_if.wdata[`RCA_CTRL_UNLOCK];
			bcd_en_ff <= reg_if.wdata[`RCA_CTRL_BCD];
			alarm_second_ones_en_ff <= reg_if.wdata[`RCA_CTRL_ALARM_SECOND_ONES_EN];
			alarm_minute_ones_en_ff <= reg_if.wdata[`RCA_CTRL_ALARM_MINUTE_ONES_EN];
		end
	end

	// ----------------------------------------------------------------
	// alarm compare
	// ----------------------------------------------------------------
	wire logic any_en;
	wire logic sec_ok;
	wire logic min_ok;
	wire logic match;
	wire logic flag_clr;

	// compare in the cycle after the advance or lock write, on the new value
	assign any_en = alarm_second_ones_en_ff | alarm_minute_ones_en_ff;
	assign sec_ok = !alarm_second_ones_en_ff | (sec_ff == alarm_second_point_ff);
	assign min_ok = !alarm_minute_ones_en_ff | (min_ff == alarm_minute_point_ff);
	assign match = cmp_req_ff & any_en & sec_ok & min_ok;
	assign flag_clr = reg_if.rd_stb & hit_ctrl;

	// a new match wins over a read that clears the flag in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_req_ff <= 1'b0;
			alarm_ff <= 1'b0;
		end else begin
			cmp_req_ff <= advance | lock_cmp;
			if (match) alarm_ff <= 1'b1;
			else if (flag_clr) alarm_ff <= 1'b0;
		end
	end

	assign alarm_o = alarm_ff;

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	wire logic [7:0] ctrl_rd;

	assign ctrl_rd = {alarm_ff, 3'b000, alarm_minute_ones_en_ff, alarm_second_ones_en_ff,
		bcd_en_ff, unlock_ff};

	// unmapped indices read as zero and ignore writes
	assign reg_if.rdata =
		({8{hit_sec}} & sec_ff) |
		({8{hit_min}} & min_ff) |
		({8{hit_hrs}} & hrs_ff) |
		({8{hit_wday}} & {4'h0, weekday_value_ff}) |
		({8{hit_mday}} & month_day_count_ff) |
		({8{hit_mon}} & month_count_reg_ff) |
		({8{hit_yr}} & year_count_reg_ff) |
		({8{hit_cen}} & hundred_year_reg_ff) |
		({8{hit_alarm_second_ones}} & alarm_second_point_ff) |
		({8{hit_alarm_minute_ones}} & alarm_minute_point_ff) |
		({8{hit_ctrl}} & ctrl_rd);
endmodule : rca_calendar
`default_nettype wire

// [hw/rca_defines.svh]
// offsets, field positions, reset values and count limits of the calendar block
`ifndef RCA_DEFINES_SVH
`define RCA_DEFINES_SVH

// register indices; byte address is four times the index
`define RCA_IDX_SEC 8'he0
`define RCA_IDX_MIN 8'he1
`define RCA_IDX_HRS 8'he2
`define RCA_IDX_WDAY 8'he3
`define RCA_IDX_MDAY 8'he4
`define RCA_IDX_MON 8'he5
`define RCA_IDX_YR 8'he6
`define RCA_IDX_CEN 8'he7
`define RCA_IDX_ALARM_SECOND_ONES 8'he8
`define RCA_IDX_ALARM_MINUTE_ONES 8'he9
`define RCA_IDX_CTRL 8'hed

// control register fields
`define RCA_CTRL_UNLOCK 0
`define RCA_CTRL_BCD 1
`define RCA_CTRL_ALARM_SECOND_ONES_EN 2
`define RCA_CTRL_ALARM_MINUTE_ONES_EN 3
`define RCA_CTRL_ALARM 7
`define RCA_CTRL_RESET 8'h00

// legal ranges, binary and bcd forms
`define RCA_SEC_MAX_BIN 8'h3b
`define RCA_SEC_MAX_BCD 8'h59
`define RCA_HRS_MAX_BIN 8'h17
`define RCA_HRS_MAX_BCD 8'h23
`define RCA_WDAY_MAX 8'h07
`define RCA_MDAY_MAX_BIN 8'h1f
`define RCA_MDAY_MAX_BCD 8'h31
`define RCA_MON_MAX_BIN 8'h0c
`define RCA_MON_MAX_BCD 8'h12
`define RCA_YR_MAX_BIN 8'h63
`define RCA_YR_MAX_BCD 8'h99
`define RCA_MIN_ZERO 8'h00
`define RCA_MIN_ONE 8'h01

`endif

// [hw/rca_pkg.sv]
// shared types of the calendar and alarm register block
package rca_pkg;
	typedef logic [7:0] rca_byte_t;
	typedef logic [7:0] rca_idx_t;
endpackage : rca_pkg

// [hw/rca_reg_if.sv]
// register access strobes between the bus slave and the calendar core
`timescale 1ns/1ps
`default_nettype none
interface rca_reg_if;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave (output wr_stb, output rd_stb, output idx,
		output wdata, input rdata);
	modport core (input wr_stb, input rd_stb, input idx,
		input wdata, output rdata);
endinterface : rca_reg_if
`default_nettype wire

// [hw/rca_step.sv]
// one calendar field: advance by one in bcd or binary, wrap at its limit
`timescale 1ns/1ps
`default_nettype none
module rca_step
	import rca_pkg::*;
(
	// field value and format
	input wire logic [7:0] cur_i,
	input wire logic bcd_i,
	input wire logic inc_i,
	// limits of the field
	input wire logic [7:0] min_i,
	input wire logic [7:0] max_bin_i,
	input wire logic [7:0] max_bcd_i,
	// result
	output logic [7:0] nxt_o,
	output logic carry_o
);
	wire logic [7:0] max_sel;
	wire logic at_max;
	wire logic [7:0] bin_inc;
	wire logic [7:0] bcd_inc;

	// bcd ones roll into tens at nine; out of range values still move on
	assign max_sel = bcd_i ? max_bcd_i : max_bin_i;
	assign at_max = (cur_i == max_sel);
	assign bin_inc = cur_i + 8'h01;
	assign bcd_inc = (cur_i[3:0] >= 4'h9) ?
		{cur_i[7:4] + 4'h1, 4'h0} : {cur_i[7:4], cur_i[3:0] + 4'h1};
	assign nxt_o = !inc_i ? cur_i : at_max ? min_i :
		(bcd_i ? bcd_inc : bin_inc);
	assign carry_o = inc_i & at_max;
endmodule : rca_step
`default_nettype wire

// [hw/rca_wb_slave.sv]
// classic wishbone slave: one-cycle access strobe, registered ack and data
`timescale 1ns/1ps
`default_nettype none
module rca_wb_slave
	import rca_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// core side
	rca_reg_if.slave reg_if
);
	logic ack_ff;
	logic [7:0] rd_ff;
	wire logic req;

	// one access per request; ack drops the cycle after it was given
	assign req = cyc_i & stb_i & !ack_ff;
	assign reg_if.wr_stb = req & we_i & sel_i[0];
	assign reg_if.rd_stb = req & !we_i;
	assign reg_if.idx = adr_i[9:2];
	assign reg_if.wdata = dat_i[7:0];
	assign ack_o = ack_ff;
	assign dat_o = {24'h000000, rd_ff};

	// ack and read data both come from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rd_ff <= 8'h00;
		end else begin
			ack_ff <= req;
			if (reg_if.rd_stb) rd_ff <= reg_if.rdata;
		end
	end
endmodule : rca_wb_slave
`default_nettype wire

// [test/rca_calendar_asserts.sv]
// port assertions of the calendar and alarm register block
`timescale 1ns/1ps
`default_nettype none
module rca_calendar_asserts (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// inputs of the block
	input wire logic tick_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	// outputs of the block
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic alarm_o
);
	// ---------
	// decode
	// ---------
	// a request is taken only while no ack is pending
	wire take = cyc_i && stb_i && !ack_o;
	wire rd = take && !we_i;
	wire [7:0] idx = adr_i[9:2];
	// locking the count forces a compare as well as a tick
	wire lock_wr = take && we_i && sel_i[0] && idx == 8'hed && !dat_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_of(logic [7:0] x);
		rd && idx == x ##1 ack_o;
	endsequence
	// ---------
	// checks
	// ---------
	ack_answer_a: assert property (take |=> ack_o)
		else $error("request not acked one cycle later");
	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(take))
		else $error("ack without a request");
	rdata_hold_a: assert property ($changed(dat_o) |-> ack_o && !$past(we_i))
		else $error("read data moved outside a read");
	upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("read data upper bytes not zero");
	weekday_nibble_a: assert property (rd_of(8'he3) |-> dat_o[7:4] == 4'h0)
		else $error("weekday upper nibble not zero");
	mday_nonzero_a: assert property (rd_of(8'he4) |-> dat_o[7:0] != 8'h00)
		else $error("day of month read as zero");
	unmapped_zero_a: assert property (rd_of(8'hea) |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	alarm_source_a: assert property ($rose(alarm_o) |->
		$past(tick_i, 2) || $past(lock_wr, 2))
		else $error("alarm rose without advance or lock");
endmodule : rca_calendar_asserts
bind rca_calendar rca_calendar_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.tick_i(tick_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .alarm_o(alarm_o));
`default_nettype wire

// [test/rca_host.sv]
// host cpu model driving classic wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module rca_host
	import rca_pkg::*;
(
	// clock and answer
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	// request
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [9:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	// ---------
	// master
	// ---------
	// idle bus at time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 10'h0;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	// one cycle; ok stays low if the slave never answers
	task automatic xfer(input logic w, input rca_idx_t idx,
		input rca_byte_t wd, output rca_byte_t rd, output logic ok);
		ok = 1'b0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {idx, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h0, wd};
		for (int n = 0; n < 32 && !ok; n++) begin
			@(posedge clk_i);
			ok = ack_i;
		end
		rd = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// released data shows a changed pattern, not the old value
		dat_o <= ~dat_o;
	endtask : xfer
endmodule : rca_host
`default_nettype wire

// [test/rca_calendar_tb.sv]
// self-checking bench of the calendar and alarm register block
`timescale 1ns/1ps
`default_nettype none
module rca_calendar_tb;
	import rca_pkg::*;
	typedef struct {rca_idx_t idx; rca_byte_t wd; rca_byte_t rd;} rca_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tick_i = 1'b0;
	logic cyc_i, stb_i, we_i, ack_o, alarm_o;
	logic [9:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	int miscompares = 0;
	int check_count = 0;
	// index, value written, value read back
	rca_row_t rows [10] = '{'{8'he0, 8'h10, 8'h10}, '{8'he1, 8'h20, 8'h20},
		'{8'he2, 8'h05, 8'h05}, '{8'he3, 8'hf3, 8'h03},
		'{8'he4, 8'h1f, 8'h1f}, '{8'he5, 8'h0c, 8'h0c},
		'{8'he6, 8'h63, 8'h63}, '{8'he7, 8'h63, 8'h63},
		'{8'he8, 8'h07, 8'h07}, '{8'he9, 8'h08, 8'h08}};
	// ---------
	// harness
	// ---------
	always #2 clk_i = ~clk_i;
	rca_calendar dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.alarm_o(alarm_o));
	rca_host host (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o),
		.cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
		.sel_o(sel_i), .dat_o(dat_i));
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input rca_byte_t e, input rca_byte_t g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	// a missing ack ends the run
	task automatic acc(input logic w, input rca_idx_t idx, input rca_byte_t wd,
		output rca_byte_t d);
		logic ok;
		host.xfer(w, idx, wd, d, ok);
		if (ok !== 1'b1) begin
			$display("mismatch ack expected 1 seen 0");
			miscompares++;
			conclude();
		end
	endtask : acc
	task automatic wr(input rca_idx_t idx, input rca_byte_t wd);
		rca_byte_t d;
		acc(1'b1, idx, wd, d);
	endtask : wr
	task automatic rdc(input rca_idx_t idx, input rca_byte_t e);
		rca_byte_t d;
		acc(1'b0, idx, 8'h00, d);
		chk($sformatf("reg %h", idx), e, d);
	endtask : rdc
	task automatic tick();
		@(posedge clk_i);
		tick_i <= 1'b1;
		@(posedge clk_i);
		tick_i <= 1'b0;
	endtask : tick
	// load counts unlocked, tick once locked, read the carried result
	task automatic counts(input rca_byte_t ctl, input rca_byte_t v [8],
		input rca_byte_t e [8]);
		wr(8'hed, ctl | 8'h01);
		foreach (v[i]) wr(8'he0 + 8'(i), v[i]);
		tick(); // ignored while unlocked
		wr(8'hed, ctl);
		tick();
		foreach (e[i]) rdc(8'he0 + 8'(i), e[i]); // carry and wrap
	endtask : counts
	// alarm one second ahead, set while locked
	task automatic alarm(input rca_byte_t ctl, input rca_byte_t s,
		input rca_byte_t m);
		wr(8'hed, ctl | 8'h01);
		wr(8'he0, s);
		wr(8'he1, m);
		wr(8'hed, ctl);
		wr(8'he8, s + 8'h01); // locked write
		wr(8'he9, m); // locked write
		tick();
		repeat (3) @(posedge clk_i);
		chk("alarm_o", 8'h01, {7'h00, alarm_o}); // match
		rdc(8'hed, ctl | 8'h80); // flag read clears it
		repeat (2) @(posedge clk_i);
		chk("alarm_o", 8'h00, {7'h00, alarm_o});
		tick();
		repeat (3) @(posedge clk_i);
		chk("alarm_o", 8'h00, {7'h00, alarm_o}); // no match
		// set points equal to the count, then lock: the lock forces a compare
		wr(8'he8, 8'h00);
		wr(8'he9, 8'h00);
		wr(8'hed, ctl);
		repeat (2) @(posedge clk_i);
		chk("alarm_o", 8'h01, {7'h00, alarm_o}); // forced compare
		rdc(8'hed, ctl | 8'h80);
	endtask : alarm
	// ---------
	// sequence
	// ---------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(8'hed, 8'h01);
		// second pass only reads, after a reset
		for (int p = 0; p < 2; p++) begin
			foreach (rows[i]) begin
				if (p == 0) wr(rows[i].idx, rows[i].wd);
				rdc(rows[i].idx, rows[i].rd); // kept
			end
			@(posedge clk_i);
			rst_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			chk("alarm_o", 8'h00, {7'h00, alarm_o});
			chk("dat_o", 8'h00, dat_o[7:0]);
			rst_i <= 1'b0;
		end
		rdc(8'hed, 8'h00);
		wr(8'he4, 8'h09);
		rdc(8'he4, 8'h1f); // locked write dropped
		rdc(8'hea, 8'h00);
		counts(8'h00, '{8'h3b, 8'h3b, 8'h17, 8'h07, 8'h1f, 8'h0c, 8'h63, 8'h63},
			'{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00});
		counts(8'h02, '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h19},
			'{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h20});
		alarm(8'h0c, 8'h3a, 8'h3b); // binary set points
		alarm(8'h0e, 8'h58, 8'h59); // bcd set points
		conclude();
	end
endmodule : rca_calendar_tb
`default_nettype wire
